// ===== shared/dsmb_pkg.sv
// Constants and carrier types of the drive status monitor bank.
// Assumes all users refer to names as dsmb_pkg::name.
`default_nettype none
package dsmb_pkg;
	// ********************************
	// Register indices (byte address is four times the index)
	// ********************************
	localparam logic [13:0] IDX_STATUS = 14'h2101;
	localparam logic [13:0] IDX_FREQ_CMD = 14'h2102;
	localparam logic [13:0] IDX_OUT_FREQ = 14'h2103;
	localparam logic [13:0] IDX_OUT_CUR = 14'h2104;
	localparam logic [13:0] IDX_DC_BUS = 14'h2105;
	localparam logic [13:0] IDX_OUT_VOLT = 14'h2106;
	localparam logic [13:0] IDX_STEP_NUM = 14'h2107;
	localparam logic [13:0] IDX_COUNTER = 14'h2109;
	localparam logic [13:0] IDX_PF_ANGLE = 14'h210a;
	localparam logic [13:0] IDX_TORQUE = 14'h210b;
	localparam logic [13:0] IDX_SPEED = 14'h210c;
	localparam logic [13:0] IDX_FB_PULSE = 14'h210d;
	localparam logic [13:0] IDX_CMD_PULSE = 14'h210e;
	localparam logic [13:0] IDX_ENERGY = 14'h210f;
	localparam logic [13:0] IDX_MULTI_DISP = 14'h2116;
	localparam logic [13:0] IDX_MAX_VALUE = 14'h211b;
	localparam logic [13:0] IDX_CUR_DEC = 14'h211f;
	localparam logic [13:0] IDX_DISP_CUR = 14'h2200;
	localparam logic [13:0] IDX_DISP_CNT = 14'h2201;
	localparam logic [13:0] IDX_ACT_FREQ = 14'h2202;
	localparam logic [13:0] IDX_DISP_DC = 14'h2203;
	localparam logic [13:0] IDX_DISP_VOLT = 14'h2204;
	localparam logic [13:0] IDX_DISP_ANGLE = 14'h2205;
	localparam logic [13:0] IDX_DISP_POWER = 14'h2206;
	localparam logic [13:0] IDX_DISP_SPEED = 14'h2207;
	localparam logic [13:0] IDX_DISP_TORQUE = 14'h2208;
	localparam logic [13:0] IDX_DISP_ENC = 14'h2209;
	localparam logic [13:0] IDX_PID_FB = 14'h220a;
	localparam logic [13:0] IDX_RSVD_A = 14'h220b;
	localparam logic [13:0] IDX_ACI = 14'h220c;
	localparam logic [13:0] IDX_RSVD_B = 14'h220d;
	localparam logic [13:0] IDX_IGBT_TEMP = 14'h220e;
	localparam logic [13:0] IDX_CAP_TEMP = 14'h220f;
	localparam logic [13:0] IDX_DIG_IN = 14'h2210;
	// ********************************
	// Ranges, fields, reset values
	// ********************************
	localparam logic [13:0] IDX_LO_A = 14'h2100;
	localparam logic [13:0] IDX_HI_A = 14'h211f;
	localparam logic [13:0] IDX_LO_B = 14'h2200;
	localparam logic [13:0] IDX_HI_B = 14'h2210;
	localparam int BIT_FREQ_COMM = 8;
	localparam int BIT_FREQ_ANALOG = 9;
	localparam int BIT_CMD_COMM = 10;
	localparam int BIT_PARAM_LOCK = 11;
	localparam int BIT_COPY_EN = 12;
	localparam logic [19:0] CUR_FINE_MAX = 20'h0ffff;
	localparam logic [7:0] DEC_FINE = 8'h02;
	localparam logic [7:0] DEC_COARSE = 8'h01;
	localparam logic [31:0] ACI_FULL = 32'h00002710;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [31:0] RST_BUS = 32'h00000000;

	typedef enum logic [1:0] {
		DSMB_IDLE = 2'b00,
		DSMB_ACCESS = 2'b01
	} dsmb_state_t;

	typedef struct packed {
		logic [1:0] runState;
		logic freqComm;
		logic freqAnalog;
		logic cmdComm;
		logic paramLock;
		logic copyEn;
		logic [15:0] freqCmd;
		logic [15:0] outFreq;
		logic [19:0] outCurrent;
		logic [15:0] dcBus;
		logic [15:0] outVolt;
		logic [15:0] stepNum;
		logic [15:0] counter;
		logic [15:0] pfAngle;
		logic [15:0] torque;
		logic [15:0] speedRpm;
		logic [15:0] encoderPulseFeedback;
		logic [15:0] secondPulseChannel;
		logic [15:0] energy;
		logic [15:0] multiDisp;
		logic [15:0] actFreq;
		logic [15:0] power;
		logic [15:0] dispSpeed;
		logic signed [15:0] dispTorque;
		logic [15:0] encDisp;
		logic pidEn;
		logic [15:0] pidFb;
		logic [11:0] currentAnalogInput;
		logic [15:0] igbtTemp;
		logic [15:0] capTemp;
		logic [15:0] digIn;
	} dsmb_meas_t;

	typedef struct packed {
		logic [15:0] userMaxScaleParam;
		logic [15:0] keypadScaledValueParam;
		logic [15:0] maxOutputFrequencyParam;
		logic [15:0] commFrequencySettingParam;
	} dsmb_param_t;
endpackage : dsmb_pkg
`default_nettype wire

// ===== src/dsmb_bank.sv
// Read-only status monitor register bank behind an APB slave.
// Assumes measurements and parameters are synchronous to mclk.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dsmb_bank #(
	parameter int ACI_W = 12
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire dsmb_pkg::dsmb_meas_t meas,
	input wire dsmb_pkg::dsmb_param_t params,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	// ********************************
	// Helpers
	// ********************************
	function automatic logic [15:0] scaleCur(input logic [19:0] raw);
		logic [19:0] tenth;
		tenth = raw / 20'd10;
		if (raw > dsmb_pkg::CUR_FINE_MAX)
			scaleCur = (tenth > dsmb_pkg::CUR_FINE_MAX) ? 16'hffff : tenth[15:0];
		else
			scaleCur = raw[15:0];
	endfunction : scaleCur

	function automatic logic [15:0] sat16(input logic [31:0] v);
		if (v > 32'h0000ffff)
			sat16 = 16'hffff;
		else
			sat16 = v[15:0];
	endfunction : sat16

	function automatic logic inRange(input logic [13:0] idx);
		inRange = (idx >= dsmb_pkg::IDX_LO_A && idx <= dsmb_pkg::IDX_HI_A)
			|| (idx >= dsmb_pkg::IDX_LO_B && idx <= dsmb_pkg::IDX_HI_B);
	endfunction : inRange

	// ********************************
	// Sampling and derived values
	// ********************************
	dsmb_pkg::dsmb_meas_t measQ;
	dsmb_pkg::dsmb_param_t parQ;
	logic cmdCommQ;
	logic [15:0] curQ;
	logic [7:0] decQ;
	logic [15:0] maxQ;
	logic [15:0] aciQ;
	logic [15:0] pidQ;
	logic [15:0] statusWord;
	logic [31:0] maxProd;
	logic [31:0] aciProd;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			measQ <= '0;
			parQ <= '0;
			cmdCommQ <= 1'b0;
		end
		else
		begin
			measQ <= meas;
			parQ <= params;
			cmdCommQ <= meas.cmdComm;
		end
	end

	always_comb
	begin
		statusWord = dsmb_pkg::RST_WORD;
		statusWord[1:0] = measQ.runState;
		statusWord[dsmb_pkg::BIT_FREQ_COMM] = measQ.freqComm;
		statusWord[dsmb_pkg::BIT_FREQ_ANALOG] = measQ.freqAnalog;
		statusWord[dsmb_pkg::BIT_CMD_COMM] = measQ.cmdComm;
		statusWord[dsmb_pkg::BIT_PARAM_LOCK] = measQ.paramLock;
		statusWord[dsmb_pkg::BIT_COPY_EN] = measQ.copyEn;
	end

	always_comb
	begin
		if (cmdCommQ)
			maxProd = 32'(parQ.commFrequencySettingParam) * 32'(parQ.userMaxScaleParam);
		else
			maxProd = 32'(parQ.keypadScaledValueParam) * 32'(parQ.userMaxScaleParam);
		aciProd = 32'(measQ.currentAnalogInput) * dsmb_pkg::ACI_FULL;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			curQ <= dsmb_pkg::RST_WORD;
			decQ <= dsmb_pkg::DEC_FINE;
		end
		else
		begin
			curQ <= scaleCur(measQ.outCurrent);
			if (measQ.outCurrent > dsmb_pkg::CUR_FINE_MAX)
				decQ <= dsmb_pkg::DEC_COARSE;
			else
				decQ <= dsmb_pkg::DEC_FINE;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			maxQ <= dsmb_pkg::RST_WORD;
		else if (parQ.userMaxScaleParam == 16'h0000)
			maxQ <= parQ.maxOutputFrequencyParam;
		else if (parQ.maxOutputFrequencyParam == 16'h0000)
			maxQ <= 16'hffff;
		else
			maxQ <= sat16(maxProd / 32'(parQ.maxOutputFrequencyParam));
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			aciQ <= dsmb_pkg::RST_WORD;
			pidQ <= dsmb_pkg::RST_WORD;
		end
		else
		begin
			aciQ <= sat16(aciProd / ((32'h1 << ACI_W) - 32'h1));
			pidQ <= measQ.pidEn ? measQ.pidFb : dsmb_pkg::RST_WORD;
		end
	end

	// ********************************
	// Read decode
	// ********************************
	logic [13:0] idx;
	logic [15:0] rdWord;
	logic rdHit;

	assign idx = paddr[15:2];

	always_comb
	begin
		rdHit = inRange(idx) && (paddr[1:0] == 2'b00);
		case (idx)
			dsmb_pkg::IDX_STATUS: rdWord = statusWord;
			dsmb_pkg::IDX_FREQ_CMD: rdWord = measQ.freqCmd;
			dsmb_pkg::IDX_OUT_FREQ: rdWord = measQ.outFreq;
			dsmb_pkg::IDX_OUT_CUR: rdWord = curQ;
			dsmb_pkg::IDX_DC_BUS: rdWord = measQ.dcBus;
			dsmb_pkg::IDX_OUT_VOLT: rdWord = measQ.outVolt;
			dsmb_pkg::IDX_STEP_NUM: rdWord = measQ.stepNum;
			dsmb_pkg::IDX_COUNTER: rdWord = measQ.counter;
			dsmb_pkg::IDX_PF_ANGLE: rdWord = measQ.pfAngle;
			dsmb_pkg::IDX_TORQUE: rdWord = measQ.torque;
			dsmb_pkg::IDX_SPEED: rdWord = measQ.speedRpm;
			dsmb_pkg::IDX_FB_PULSE: rdWord = measQ.encoderPulseFeedback;
			dsmb_pkg::IDX_CMD_PULSE: rdWord = measQ.secondPulseChannel;
			dsmb_pkg::IDX_ENERGY: rdWord = measQ.energy;
			dsmb_pkg::IDX_MULTI_DISP: rdWord = measQ.multiDisp;
			dsmb_pkg::IDX_MAX_VALUE: rdWord = maxQ;
			dsmb_pkg::IDX_CUR_DEC: rdWord = {decQ, 8'h00};
			dsmb_pkg::IDX_DISP_CUR: rdWord = curQ;
			dsmb_pkg::IDX_DISP_CNT: rdWord = measQ.counter;
			dsmb_pkg::IDX_ACT_FREQ: rdWord = measQ.actFreq;
			dsmb_pkg::IDX_DISP_DC: rdWord = measQ.dcBus;
			dsmb_pkg::IDX_DISP_VOLT: rdWord = measQ.outVolt;
			dsmb_pkg::IDX_DISP_ANGLE: rdWord = measQ.pfAngle;
			dsmb_pkg::IDX_DISP_POWER: rdWord = measQ.power;
			dsmb_pkg::IDX_DISP_SPEED: rdWord = measQ.dispSpeed;
			dsmb_pkg::IDX_DISP_TORQUE: rdWord = measQ.dispTorque;
			dsmb_pkg::IDX_DISP_ENC: rdWord = measQ.encDisp;
			dsmb_pkg::IDX_PID_FB: rdWord = pidQ;
			dsmb_pkg::IDX_ACI: rdWord = aciQ;
			dsmb_pkg::IDX_IGBT_TEMP: rdWord = measQ.igbtTemp;
			dsmb_pkg::IDX_CAP_TEMP: rdWord = measQ.capTemp;
			dsmb_pkg::IDX_DIG_IN: rdWord = measQ.digIn;
			default: rdWord = dsmb_pkg::RST_WORD;
		endcase
	end

	// ********************************
	// APB slave
	// ********************************
	dsmb_pkg::dsmb_state_t state_q;
	logic setup;

	assign setup = psel && !penable;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			state_q <= dsmb_pkg::DSMB_IDLE;
		else
			case (state_q)
				dsmb_pkg::DSMB_IDLE: state_q <= setup ? dsmb_pkg::DSMB_ACCESS : dsmb_pkg::DSMB_IDLE;
				dsmb_pkg::DSMB_ACCESS: state_q <= dsmb_pkg::DSMB_IDLE;
				default: state_q <= dsmb_pkg::DSMB_IDLE;
			endcase
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			prdata <= dsmb_pkg::RST_BUS;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (setup && state_q == dsmb_pkg::DSMB_IDLE)
		begin
			pready <= 1'b1;
			pslverr <= !rdHit;
			prdata <= (pwrite || !rdHit) ? dsmb_pkg::RST_BUS : {16'h0000, rdWord};
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= dsmb_pkg::RST_BUS;
		end
	end

	// ********************************
	// Checks
	// ********************************
	logic rdAcc;
	logic rdStatus;
	assign rdAcc = setup && state_q == dsmb_pkg::DSMB_IDLE && !pwrite && paddr[1:0] == 2'b00;
	assign rdStatus = rdAcc && idx == dsmb_pkg::IDX_STATUS;

	property p_src_bits;
		@(posedge mclk) disable iff (sys_rst)
		rdStatus |=> prdata[10:8] == {$past(measQ.cmdComm), $past(measQ.freqAnalog), $past(measQ.freqComm)};
	endproperty
	a_src_bits: assert property (p_src_bits) else $error("source bits wrong");

	property p_lock_bits;
		@(posedge mclk) disable iff (sys_rst)
		rdStatus |=> prdata[15:11] == {3'b000, $past(measQ.copyEn), $past(measQ.paramLock)};
	endproperty
	a_lock_bits: assert property (p_lock_bits) else $error("lock bits wrong");

	property p_run_state;
		@(posedge mclk) disable iff (sys_rst)
		rdStatus |=> prdata[1:0] == $past(measQ.runState);
	endproperty
	a_run_state: assert property (p_run_state) else $error("run state wrong");

	property p_cur_scale;
		@(posedge mclk) disable iff (sys_rst)
		measQ.outCurrent > dsmb_pkg::CUR_FINE_MAX |=> decQ == dsmb_pkg::DEC_COARSE && curQ >= 16'h1999;
	endproperty
	a_cur_scale: assert property (p_cur_scale) else $error("current scale wrong");

	property p_max_zero;
		@(posedge mclk) disable iff (sys_rst)
		parQ.userMaxScaleParam == 16'h0000 |=> maxQ == $past(parQ.maxOutputFrequencyParam);
	endproperty
	a_max_zero: assert property (p_max_zero) else $error("max value wrong");

	property p_write_void;
		@(posedge mclk) disable iff (sys_rst)
		setup && state_q == dsmb_pkg::DSMB_IDLE && pwrite |=> pready && prdata == dsmb_pkg::RST_BUS;
	endproperty
	a_write_void: assert property (p_write_void) else $error("write not ignored");

	property p_rsvd_zero;
		@(posedge mclk) disable iff (sys_rst)
		setup && state_q == dsmb_pkg::DSMB_IDLE && paddr[1:0] == 2'b00
			&& (idx == dsmb_pkg::IDX_RSVD_A || idx == dsmb_pkg::IDX_RSVD_B)
			|=> prdata == dsmb_pkg::RST_BUS && !pslverr;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved not zero");

	property p_pid_gate;
		@(posedge mclk) disable iff (sys_rst)
		!measQ.pidEn |=> pidQ == dsmb_pkg::RST_WORD;
	endproperty
	a_pid_gate: assert property (p_pid_gate) else $error("pid not gated");

	property p_aci_range;
		@(posedge mclk) disable iff (sys_rst)
		aciQ <= dsmb_pkg::ACI_FULL[15:0];
	endproperty
	a_aci_range: assert property (p_aci_range) else $error("aci out of range");

	property p_freq_pass;
		@(posedge mclk) disable iff (sys_rst)
		rdAcc && idx == dsmb_pkg::IDX_FREQ_CMD |=> prdata == {16'h0000, $past(measQ.freqCmd)};
	endproperty
	a_freq_pass: assert property (p_freq_pass) else $error("frequency command wrong");

	property p_out_freq;
		@(posedge mclk) disable iff (sys_rst)
		rdAcc && idx == dsmb_pkg::IDX_OUT_FREQ |=> prdata == {16'h0000, $past(measQ.outFreq)};
	endproperty
	a_out_freq: assert property (p_out_freq) else $error("output frequency wrong");

	property p_volt_pass;
		@(posedge mclk) disable iff (sys_rst)
		rdAcc && idx == dsmb_pkg::IDX_DC_BUS |=> prdata == {16'h0000, $past(measQ.dcBus)};
	endproperty
	a_volt_pass: assert property (p_volt_pass) else $error("bus voltage wrong");

	property p_volt_disp;
		@(posedge mclk) disable iff (sys_rst)
		rdAcc && idx == dsmb_pkg::IDX_DISP_VOLT |=> prdata == {16'h0000, $past(measQ.outVolt)};
	endproperty
	a_volt_disp: assert property (p_volt_disp) else $error("output voltage wrong");

	property p_pulse_cnt;
		@(posedge mclk) disable iff (sys_rst)
		rdAcc && idx == dsmb_pkg::IDX_FB_PULSE |=> prdata == {16'h0000, $past(measQ.encoderPulseFeedback)};
	endproperty
	a_pulse_cnt: assert property (p_pulse_cnt) else $error("pulse count wrong");

	property p_torque_sign;
		@(posedge mclk) disable iff (sys_rst)
		rdAcc && idx == dsmb_pkg::IDX_DISP_TORQUE |=> prdata == {16'h0000, $past(measQ.dispTorque)};
	endproperty
	a_torque_sign: assert property (p_torque_sign) else $error("torque wrong");

	property p_temp_pass;
		@(posedge mclk) disable iff (sys_rst)
		rdAcc && idx == dsmb_pkg::IDX_IGBT_TEMP |=> prdata == {16'h0000, $past(measQ.igbtTemp)};
	endproperty
	a_temp_pass: assert property (p_temp_pass) else $error("temperature wrong");

	property p_energy_pass;
		@(posedge mclk) disable iff (sys_rst)
		rdAcc && idx == dsmb_pkg::IDX_ENERGY |=> prdata == {16'h0000, $past(measQ.energy)};
	endproperty
	a_energy_pass: assert property (p_energy_pass) else $error("energy wrong");

	property p_speed_pass;
		@(posedge mclk) disable iff (sys_rst)
		rdAcc && idx == dsmb_pkg::IDX_SPEED |=> prdata == {16'h0000, $past(measQ.speedRpm)};
	endproperty
	a_speed_pass: assert property (p_speed_pass) else $error("speed wrong");

	property p_cur_read;
		@(posedge mclk) disable iff (sys_rst)
		rdAcc && (idx == dsmb_pkg::IDX_OUT_CUR || idx == dsmb_pkg::IDX_DISP_CUR) |=> prdata == {16'h0000, $past(curQ)};
	endproperty
	a_cur_read: assert property (p_cur_read) else $error("current read wrong");

	property p_fine_cur;
		@(posedge mclk) disable iff (sys_rst)
		measQ.outCurrent[19:16] == 4'h0 |=> decQ == dsmb_pkg::DEC_FINE && curQ == $past(measQ.outCurrent[15:0]);
	endproperty
	a_fine_cur: assert property (p_fine_cur) else $error("fine current wrong");

	property p_err_range;
		@(posedge mclk) disable iff (sys_rst)
		setup && state_q == dsmb_pkg::DSMB_IDLE && !inRange(idx) |=> pslverr && prdata == dsmb_pkg::RST_BUS;
	endproperty
	a_err_range: assert property (p_err_range) else $error("unmapped not refused");

	property p_no_wait;
		@(posedge mclk) disable iff (sys_rst)
		setup && state_q == dsmb_pkg::DSMB_IDLE |=> pready;
	endproperty
	a_no_wait: assert property (p_no_wait) else $error("answer missing");
endmodule : dsmb_bank
`default_nettype wire

// ===== test/dsmb_host.sv
// Host model: APB master that reads and writes the monitor bank.
// Assumes one clock, mclk; callers enter tasks just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module dsmb_host (
	input wire logic mclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [15:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h00000000;
	end
	// ********************************
	// One transfer: setup, then access until pready
	// ********************************
	task automatic xfer(input logic wr, input logic [13:0] idx, output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= 32'h5a5aa5a5;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
		begin
			@(posedge mclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : dsmb_host
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench of the status monitor bank.
// Assumes the host model drives APB; measurements are driven here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	dsmb_pkg::dsmb_meas_t meas = '0;
	dsmb_pkg::dsmb_param_t params = '0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic e;
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	always #12.5 mclk = ~mclk;
	dsmb_bank dsmb_bank_inst (.mclk(mclk), .sys_rst(sys_rst), .meas(meas), .params(params), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	dsmb_host dsmb_host_inst (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	// ********************************
	// Checking helpers
	// ********************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [13:0] idx, input logic [31:0] exp);
		repeat (3) @(posedge mclk);
		dsmb_host_inst.xfer(1'b0, idx, d, e);
		chk(d, exp);
		chk({31'h0, e}, 32'h00000000);
	endtask : rd
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_count++;
			conclude();
		end
	end
	// ********************************
	// Test sequence
	// ********************************
	initial
	begin
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < 4; i++)
		begin
			meas.runState <= i[1:0];
			meas.freqComm <= i[0];
			meas.freqAnalog <= i[1];
			meas.cmdComm <= ~i[0];
			meas.paramLock <= ~i[1];
			meas.copyEn <= i[0];
			rd(dsmb_pkg::IDX_STATUS, {19'h0, i[0], ~i[1], ~i[0], i[1], i[0], 6'h00, i[1:0]});
		end
		$display("test status word done");
		meas.outCurrent <= 20'h0ffff;
		rd(dsmb_pkg::IDX_OUT_CUR, 32'h0000ffff);
		rd(dsmb_pkg::IDX_DISP_CUR, 32'h0000ffff);
		rd(dsmb_pkg::IDX_CUR_DEC, 32'h00000200);
		meas.outCurrent <= 20'h10000;
		rd(dsmb_pkg::IDX_OUT_CUR, 32'h00001999);
		rd(dsmb_pkg::IDX_DISP_CUR, 32'h00001999);
		rd(dsmb_pkg::IDX_CUR_DEC, 32'h00000100);
		$display("test current scaling done");
		params <= '{16'h0000, 16'h0bb8, 16'h1770, 16'h04b0};
		rd(dsmb_pkg::IDX_MAX_VALUE, 32'h00001770);
		params.userMaxScaleParam <= 16'h03e8;
		meas.cmdComm <= 1'b0;
		rd(dsmb_pkg::IDX_MAX_VALUE, 32'h000001f4);
		meas.cmdComm <= 1'b1;
		rd(dsmb_pkg::IDX_MAX_VALUE, 32'h000000c8);
		$display("test max value done");
		meas.freqCmd <= 16'hea60;
		meas.outFreq <= 16'h1771;
		meas.dcBus <= 16'h0d05;
		meas.outVolt <= 16'h0898;
		meas.encoderPulseFeedback <= 16'hffff;
		meas.secondPulseChannel <= 16'h0000;
		meas.dispTorque <= -16'sd5;
		meas.igbtTemp <= 16'h01c2;
		meas.capTemp <= 16'h0177;
		meas.energy <= 16'h3039;
		meas.speedRpm <= 16'h0708;
		rd(dsmb_pkg::IDX_FREQ_CMD, 32'h0000ea60);
		rd(dsmb_pkg::IDX_OUT_FREQ, 32'h00001771);
		rd(dsmb_pkg::IDX_DC_BUS, 32'h00000d05);
		rd(dsmb_pkg::IDX_DISP_VOLT, 32'h00000898);
		rd(dsmb_pkg::IDX_FB_PULSE, 32'h0000ffff);
		rd(dsmb_pkg::IDX_CMD_PULSE, 32'h00000000);
		rd(dsmb_pkg::IDX_DISP_TORQUE, 32'h0000fffb);
		rd(dsmb_pkg::IDX_IGBT_TEMP, 32'h000001c2);
		rd(dsmb_pkg::IDX_CAP_TEMP, 32'h00000177);
		rd(dsmb_pkg::IDX_ENERGY, 32'h00003039);
		rd(dsmb_pkg::IDX_SPEED, 32'h00000708);
		meas.counter <= 16'h0064;
		meas.stepNum <= 16'h0003;
		rd(dsmb_pkg::IDX_COUNTER, 32'h00000064);
		rd(dsmb_pkg::IDX_DISP_CNT, 32'h00000064);
		rd(dsmb_pkg::IDX_STEP_NUM, 32'h00000003);
		$display("test passthrough done");
		meas.currentAnalogInput <= 12'hfff;
		rd(dsmb_pkg::IDX_ACI, 32'h00002710);
		meas.currentAnalogInput <= 12'h800;
		rd(dsmb_pkg::IDX_ACI, 32'h00001389);
		meas.pidFb <= 16'h1234;
		rd(dsmb_pkg::IDX_PID_FB, 32'h00000000);
		meas.pidEn <= 1'b1;
		rd(dsmb_pkg::IDX_PID_FB, 32'h00001234);
		$display("test analog and pid done");
		@(posedge mclk);
		dsmb_host_inst.xfer(1'b1, dsmb_pkg::IDX_FREQ_CMD, d, e);
		chk(d, 32'h00000000);
		chk({31'h0, e}, 32'h00000000);
		rd(dsmb_pkg::IDX_FREQ_CMD, 32'h0000ea60);
		rd(dsmb_pkg::IDX_FREQ_CMD, 32'h0000ea60);
		rd(dsmb_pkg::IDX_RSVD_A, 32'h00000000);
		rd(dsmb_pkg::IDX_RSVD_B, 32'h00000000);
		rd(14'h2108, 32'h00000000);
		@(posedge mclk);
		dsmb_host_inst.xfer(1'b0, 14'h2300, d, e);
		chk(d, 32'h00000000);
		chk({31'h0, e}, 32'h00000001);
		$display("test access rules done");
		conclude();
	end
endmodule : testbench
`default_nettype wire
